// ---- rtl/sgp_pkg.sv ----
// package for the six-bit general purpose port: offsets, reset values, widths
// Functional notes
// - six pins, each direction, latch, analog bit
// - direction one disables driver, zero drives latch
// - input-only pin never drives, reads one
// - data read returns pins, write hits latch
// - every port write is read-modify-write
// - direction controls driver even in analog
// - analog bit forces digital reads to zero
// - analog bit leaves digital output untouched
// - analog bits reset to analog setting
// - highest priority enabled source owns pin
// - fixed per-pin peripheral priority order
// - analog inputs connect only in analog mode
// - logic cell one on pin two, movable
package sgp_pkg;
   localparam int unsigned PORT_W    = 6;
   localparam int unsigned INONLY    = 3;
   localparam int unsigned ALT_PIN   = 5;
   // register byte offsets
   localparam logic [7:0] OFF_PIN    = 8'h00;
   localparam logic [7:0] OFF_LATCH  = 8'h04;
   localparam logic [7:0] OFF_DIR    = 8'h08;
   localparam logic [7:0] OFF_ANSEL  = 8'h0c;
   localparam logic [7:0] OFF_ALTSEL = 8'h10;
   // values after reset, then axi response codes
   localparam logic [5:0] RST_DIR    = 6'h3f;
   localparam logic [5:0] RST_ANSEL  = 6'h3f;
   localparam logic [5:0] RST_LATCH  = 6'h00;
   localparam logic       RST_ALT    = 1'b0;
   localparam logic [1:0] RESP_OK    = 2'h0;
   localparam logic [1:0] RESP_ERR   = 2'h2;
endpackage : sgp_pkg

// ---- rtl/sgp_sync.sv ----
// two-flop synchroniser for the pin inputs
`timescale 1ns/10ps
module sgp_sync (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic [5:0] din,
   output logic      [5:0] dout
);
   logic [5:0] meta;

   // first stage feeds only the second
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta <= 6'h00;
         dout <= 6'h00;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule : sgp_sync

// ---- rtl/sgp_port.sv ----
// six-bit general purpose port with axi4-lite registers and output priority
`timescale 1ns/10ps
module sgp_port (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [5:0]  pin_in,
   output logic [5:0]       pin_out,
   output logic [5:0]       pin_oe,
   output logic [5:0]       analog_connect,
   input  wire logic        programming_data_en,
   input  wire logic        programming_data_out,
   input  wire logic        dac_output_one_en,
   input  wire logic        dac_output_one,
   input  wire logic        dac_output_two_en,
   input  wire logic        dac_output_two,
   input  wire logic        logic_cell_one_en,
   input  wire logic        logic_cell_one_out,
   input  wire logic        comparator_one_en,
   input  wire logic        comparator_one_out,
   input  wire logic        pwm_three_en,
   input  wire logic        pwm_three_out,
   input  wire logic        clock_output_en,
   input  wire logic        clock_output,
   input  wire logic        secondary_osc_out_en,
   input  wire logic        secondary_osc_out,
   input  wire logic        secondary_osc_in_en,
   input  wire logic        secondary_osc_in
);
   logic [5:0] port_output_latch;
   logic [5:0] port_direction;
   logic [5:0] port_analog_select;
   logic       alternate_pin_select;
   logic [5:0] pin_sync;
   logic       aw_held;
   logic       w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   ////////////////////////////////////////////////////////////////////////////
   // pin input path

   sgp_sync u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .din     (pin_in),
      .dout    (pin_sync)
   );

   wire [5:0] port_pin_data = pin_sync & ~port_analog_select;

   // analog inputs only in analog mode
   assign analog_connect = port_analog_select;

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite write channel: address and data taken in either order

   wire do_write  = aw_held && w_held && !s_axi_bvalid;
   wire [7:0] wa  = aw_addr;
   wire wr_lo     = w_strb[0];
   wire [5:0] wv  = w_data[5:0];
   wire wr_pin    = do_write && wr_lo && (wa == sgp_pkg::OFF_PIN);
   wire wr_latch  = do_write && wr_lo && (wa == sgp_pkg::OFF_LATCH);
   wire wr_dir    = do_write && wr_lo && (wa == sgp_pkg::OFF_DIR);
   wire wr_ansel  = do_write && wr_lo && (wa == sgp_pkg::OFF_ANSEL);
   wire wr_alt    = do_write && wr_lo && (wa == sgp_pkg::OFF_ALTSEL);
   wire wa_known  = (wa == sgp_pkg::OFF_PIN) || (wa == sgp_pkg::OFF_LATCH) ||
                    (wa == sgp_pkg::OFF_DIR) || (wa == sgp_pkg::OFF_ANSEL) ||
                    (wa == sgp_pkg::OFF_ALTSEL);

   assign s_axi_awready = !aw_held;
   assign s_axi_wready  = !w_held;

   // hold address and data until both are present
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= 8'h00;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
      end else begin
         if (s_axi_awvalid && !aw_held) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid && !w_held) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (do_write) begin
            w_held <= 1'b0;
         end
      end
   end

   // write response, slverr on unmapped offsets
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= sgp_pkg::RESP_OK;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wa_known ? sgp_pkg::RESP_OK : sgp_pkg::RESP_ERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // port registers

   // full-byte pin write modifies every bit, so written value is the result
   // a pin write only reaches the latch
   wire [5:0] next_latch = wr_pin   ? wv :
                           wr_latch ? wv : port_output_latch;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         port_output_latch    <= sgp_pkg::RST_LATCH;
         port_direction       <= sgp_pkg::RST_DIR;
         port_analog_select   <= sgp_pkg::RST_ANSEL;
         alternate_pin_select <= sgp_pkg::RST_ALT;
      end else begin
         port_output_latch <= next_latch;
         if (wr_dir) begin
            port_direction <= wv | (6'h01 << sgp_pkg::INONLY);
         end
         if (wr_ansel) begin
            port_analog_select <= wv;
         end
         if (wr_alt) begin
            alternate_pin_select <= w_data[0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite read channel

   wire [7:0] ra = s_axi_araddr;
   wire ra_known = (ra == sgp_pkg::OFF_PIN) || (ra == sgp_pkg::OFF_LATCH) ||
                   (ra == sgp_pkg::OFF_DIR) || (ra == sgp_pkg::OFF_ANSEL) ||
                   (ra == sgp_pkg::OFF_ALTSEL);
   wire [5:0] rsel = (ra == sgp_pkg::OFF_PIN)    ? port_pin_data :
                     (ra == sgp_pkg::OFF_LATCH)  ? port_output_latch :
                     (ra == sgp_pkg::OFF_DIR)    ? port_direction :
                     (ra == sgp_pkg::OFF_ANSEL)  ? port_analog_select :
                     (ra == sgp_pkg::OFF_ALTSEL) ? {5'h00, alternate_pin_select} :
                     6'h00;

   assign s_axi_arready = !s_axi_rvalid;

   // one read outstanding; answer the cycle after the address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= sgp_pkg::RESP_OK;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= {26'h0, rsel};
         s_axi_rresp  <= ra_known ? sgp_pkg::RESP_OK : sgp_pkg::RESP_ERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // output priority per pin

   // logic cell one default pin two, alternate pin five
   wire lc_p2 = logic_cell_one_en && !alternate_pin_select;
   wire lc_p5 = logic_cell_one_en && alternate_pin_select;

   wire d0 = programming_data_en ? programming_data_out :
             dac_output_one_en   ? dac_output_one : port_output_latch[0];
   wire d2 = dac_output_two_en   ? dac_output_two :
             lc_p2               ? logic_cell_one_out :
             comparator_one_en   ? comparator_one_out :
             pwm_three_en        ? pwm_three_out : port_output_latch[2];
   wire d4 = clock_output_en     ? clock_output :
             secondary_osc_out_en ? secondary_osc_out : port_output_latch[4];
   wire d5 = secondary_osc_in_en ? secondary_osc_in :
             lc_p5               ? logic_cell_one_out : port_output_latch[5];
   wire [5:0] drive_val = {d5, d4, 1'b0, d2, port_output_latch[1], d0};

   // direction alone gates driver; analog bits not used
   wire [5:0] next_oe = ~port_direction & ~(6'h01 << sgp_pkg::INONLY);

   // registered pin drive
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_out <= 6'h00;
         pin_oe  <= 6'h00;
      end else begin
         pin_out <= drive_val & next_oe;
         pin_oe  <= next_oe;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   // input-only bit as a mask, so checks need not spell the pin
   wire [5:0] inonly_mask = 6'h01 << sgp_pkg::INONLY;

   // direction and driver enable
   // input-only never drives
   a_inonly_no_drive: assert property (
      @(posedge aclk) disable iff (!aresetn)
      !pin_oe[sgp_pkg::INONLY])
      else $error("input-only pin driven");
   a_inonly_dir_one: assert property (
      @(posedge aclk) disable iff (!aresetn)
      port_direction[sgp_pkg::INONLY])
      else $error("input-only direction bit clear");
   a_dir_write_forced: assert property (
      @(posedge aclk) disable iff (!aresetn)
      wr_dir |=> port_direction == ($past(wv) | inonly_mask))
      else $error("direction write lost or input-only bit cleared");
   a_dir_gates_oe: assert property (
      @(posedge aclk) disable iff (!aresetn)
      port_direction[0] |=> !pin_oe[0] || $past(port_direction[0]) == 1'b0)
      else $error("driver on with direction set");
   a_oe_follows_dir: assert property (
      @(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |-> pin_oe == (~$past(port_direction) & ~inonly_mask))
      else $error("driver enable does not follow direction");
   a_analog_drives: assert property (
      @(posedge aclk) disable iff (!aresetn)
      !port_direction[1] && port_analog_select[1] |=>
         pin_oe[1] && pin_out[1] == $past(port_output_latch[1]))
      else $error("analog pin output blocked");
   a_undriven_low: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (pin_out & ~pin_oe) == 6'h00)
      else $error("value shown on undriven pad");

   // output priority
   // programming data first
   a_pin0_prio: assert property (
      @(posedge aclk) disable iff (!aresetn)
      programming_data_en && !port_direction[0] |=> pin_out[0] == $past(programming_data_out))
      else $error("pin 0 priority wrong");
   a_pin1_latch_only: assert property (
      @(posedge aclk) disable iff (!aresetn)
      !port_direction[1] |=> pin_out[1] == $past(port_output_latch[1]))
      else $error("pin 1 not driven from latch");
   a_pin2_dac_first: assert property (
      @(posedge aclk) disable iff (!aresetn)
      dac_output_two_en && !port_direction[2] |=> pin_out[2] == $past(dac_output_two))
      else $error("pin 2 priority wrong");
   a_cell_default_pin: assert property (
      @(posedge aclk) disable iff (!aresetn)
      logic_cell_one_en && !alternate_pin_select && !dac_output_two_en &&
         !port_direction[2] |=> pin_out[2] == $past(logic_cell_one_out))
      else $error("logic cell missing on its default pin");
   a_cell_alt_pin: assert property (
      @(posedge aclk) disable iff (!aresetn)
      logic_cell_one_en && alternate_pin_select && !secondary_osc_in_en &&
         !port_direction[5] |=> pin_out[5] == $past(logic_cell_one_out))
      else $error("logic cell missing on its alternate pin");
   a_pin4_clock_first: assert property (
      @(posedge aclk) disable iff (!aresetn)
      clock_output_en && !port_direction[4] |=> pin_out[4] == $past(clock_output))
      else $error("pin 4 priority wrong");
   a_pin5_osc_first: assert property (
      @(posedge aclk) disable iff (!aresetn)
      secondary_osc_in_en && !port_direction[5] |=> pin_out[5] == $past(secondary_osc_in))
      else $error("pin 5 priority wrong");

   // register paths and reset
   // latch write lands
   a_write_latch: assert property (
      @(posedge aclk) disable iff (!aresetn)
      wr_latch |=> port_output_latch == $past(wv))
      else $error("latch write lost");
   a_rmw_latch: assert property (
      @(posedge aclk) disable iff (!aresetn)
      wr_pin |=> port_output_latch == $past(wv))
      else $error("port write did not reach latch");
   a_pin_read_levels: assert property (
      @(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready && s_axi_araddr == sgp_pkg::OFF_PIN |=>
         s_axi_rdata[5:0] == ($past(pin_sync) & ~$past(port_analog_select)))
      else $error("pin read does not show synchronised levels");
   a_analog_reads_zero: assert property (
      @(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready && s_axi_araddr == sgp_pkg::OFF_PIN |=>
         (s_axi_rdata[5:0] & $past(port_analog_select)) == 6'h00)
      else $error("analog pin read nonzero");
   a_reset_analog: assert property (
      @(posedge aclk)
      !aresetn |=> port_analog_select == sgp_pkg::RST_ANSEL)
      else $error("analog reset lost");
   a_sync_delay: assert property (
      @(posedge aclk) disable iff (!aresetn)
      $past(aresetn) && $past(aresetn, 2) |-> pin_sync == $past(pin_in, 2))
      else $error("pin levels not delayed by two flops");
endmodule : sgp_port

// ---- tb/sgp_pad_model.sv ----
// far side of the port: pads with an outside source behind each one
`timescale 1ns/10ps
module sgp_pad_model (
   input  wire logic [5:0] ext_level,
   input  wire logic [5:0] pin_out,
   input  wire logic [5:0] pin_oe,
   output logic      [5:0] pin_in
);
   // pad follows driver
   // an enabled port driver wins; otherwise the outside source sets the pad
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : sgp_pad_model

// ---- tb/tb_six_bit_gpio_port.sv ----
// self-checking bench for the six-bit port
`timescale 1ns/10ps
module tb_six_bit_gpio_port;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, alt;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [1:0]  bresp, rresp, rsp;
   logic [5:0]  pin_in, pin_out, pin_oe, ana_con, ext, lat, ana;
   logic [17:0] per;
   int          mismatches, num_checks, seed, i;
   int          cyc = 0;

   sgp_port dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .analog_connect(ana_con), .programming_data_en(per[0]),
      .programming_data_out(per[1]), .dac_output_one_en(per[2]),
      .dac_output_one(per[3]), .dac_output_two_en(per[4]), .dac_output_two(per[5]),
      .logic_cell_one_en(per[6]), .logic_cell_one_out(per[7]),
      .comparator_one_en(per[8]), .comparator_one_out(per[9]),
      .pwm_three_en(per[10]), .pwm_three_out(per[11]), .clock_output_en(per[12]),
      .clock_output(per[13]), .secondary_osc_out_en(per[14]),
      .secondary_osc_out(per[15]), .secondary_osc_in_en(per[16]),
      .secondary_osc_in(per[17]));
   sgp_pad_model pad_u (.ext_level(ext), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_in(pin_in));

   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   ////////////////////////////////////////////////////////////////////////////
   // compare, count and report
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : results

   // write: address and data offered together, each released once taken
   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      r = bresp;
      bready <= 1'b0;
   endtask : axw

   // read: rready held until the answer is sampled
   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : axr

   // expected pad drive: fixed priority, highest first, latch last
   function automatic logic [5:0] exp_out(input logic [17:0] p, input logic [5:0] l,
                                           input logic a);
      logic [5:0] o;
      o    = l;
      o[0] = p[0] ? p[1] : p[2] ? p[3] : l[0];
      o[2] = p[4] ? p[5] : (p[6] && !a) ? p[7] : p[8] ? p[9] : p[10] ? p[11] : l[2];
      o[3] = 1'b0;
      o[4] = p[12] ? p[13] : p[14] ? p[15] : l[4];
      o[5] = p[16] ? p[17] : (p[6] && a) ? p[7] : l[5];
      return o;
   endfunction : exp_out

   ////////////////////////////////////////////////////////////////////////////
   // bounded run length
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         mismatches++;
         results;
      end
   end

   initial begin
      seed = 32'h611a;
      {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
      {aresetn, per, ext, mismatches, num_checks} = '0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      axr(sgp_pkg::OFF_LATCH, rd, rsp); chk("latch", 32'h0, rd);
      axr(sgp_pkg::OFF_DIR, rd, rsp); chk("dir", 32'h3f, rd);
      axr(sgp_pkg::OFF_ANSEL, rd, rsp); chk("ansel", 32'h3f, rd);
      chk("oe", 6'h00, pin_oe);
      axw(sgp_pkg::OFF_DIR, 32'h0, rsp);
      axr(sgp_pkg::OFF_DIR, rd, rsp); chk("dir", 32'h08, rd);
      // priority mux, analog left set so drive must still reach the pads
      for (i = 0; i < 40; i++) begin
         lat = $random(seed);
         alt = (i > 20) ? $random(seed) : 1'b0;
         axw(sgp_pkg::OFF_LATCH, {26'h0, lat}, rsp);
         axw(sgp_pkg::OFF_ALTSEL, {31'h0, alt}, rsp);
         per <= (i == 0) ? 18'h0 : (i == 1) ? 18'h3ffff : $random(seed);
         repeat (3) @(posedge aclk);
         chk("oe", 6'h37, pin_oe);
         chk("pad", exp_out(per, lat, alt), pin_out & pin_oe);
      end
      // pad reads masked by analog select, inputs synchronised
      axw(sgp_pkg::OFF_DIR, 32'h3f, rsp);
      for (i = 0; i < 8; i++) begin
         ana = (i == 0) ? 6'h00 : $random(seed);
         ext <= $random(seed);
         axw(sgp_pkg::OFF_ANSEL, {26'h0, ana}, rsp);
         chk("acon", ana, ana_con);
         repeat (4) @(posedge aclk);
         axr(sgp_pkg::OFF_PIN, rd, rsp); chk("pins", {26'h0, ext & ~ana}, rd);
         axw(sgp_pkg::OFF_PIN, {26'h0, ~ext}, rsp);
         axr(sgp_pkg::OFF_LATCH, rd, rsp); chk("rmw", {26'h0, ~ext}, rd);
      end
      // reset in mid-run, after analog bits were rewritten by software
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      axr(sgp_pkg::OFF_ANSEL, rd, rsp); chk("ansel", 32'h3f, rd);
      axr(sgp_pkg::OFF_LATCH, rd, rsp); chk("latch", 32'h0, rd);
      chk("oe", 6'h00, pin_oe);
      chk("acon", 6'h3f, ana_con);
      // unmapped offset refused on both channels
      axw(8'h14, 32'h3f, rsp); chk("bresp", sgp_pkg::RESP_ERR, rsp);
      axr(8'h14, rd, rsp); chk("rresp", sgp_pkg::RESP_ERR, rsp);
      chk("rdata", 32'h0, rd);
      results;
   end
endmodule : tb_six_bit_gpio_port
